// file: verilog/adc_accum_pkg.sv
// constants and types for the conversion result accumulator and filter
// What this block does
// - three-bit mode picks basic, accumulate, average, burst average or low-pass.
// - basic mode flags done only after one or both samples convert.
// - basic mode leaves accumulator and count alone but still tests threshold.
// - accumulate mode adds, counts, flags done and tests every sample.
// - accumulate mode copies accumulator shifted right into filtered result.
// - average mode tests at repeat target, restarts sum at next sample.
// - burst mode clears at trigger, retriggers until count reaches target when double sampling is off.
// - low-pass mode updates sample plus acc minus shifted acc, tests at and past target.
// - with double sampling the second minus first sample is used.
// - sample count increments per accumulated sample, holding at ff.
// - go bit write or external trigger starts an accumulation step.
// - accumulator is 16 bits; carry out sets the overflow flag.
// - clear command zeroes accumulator, overflow and count, then drops itself.
// - clearing takes five converter clock cycles.
// - average and burst modes shift the sum right to form the result.
// - low-pass shift of 1 to 7 sets the filter cut-off.
// - continuous sampling keeps go set and starts the next conversion.
package adc_accum_pkg;
	localparam int ACC_W     = 16;
	localparam int CNT_W     = 8;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int CLR_CNT_W = 3;
	localparam int STAT_W    = 3;

	typedef enum logic [2:0] {
		MODE_BASIC   = 3'b000,
		MODE_ACCUM   = 3'b001,
		MODE_AVERAGE = 3'b010,
		MODE_BURST   = 3'b011,
		MODE_LOWPASS = 3'b100
	} compute_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01
	} seq_state_e;

	typedef struct packed {
		logic              valid;
		logic [ACC_W-1:0]  conversion_result;
		logic              thresholdHit;
	} conv_sample_s;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_rsp_s;

	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_REPEAT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_ACCUM  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_FILTER = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_PREV   = 8'h1c;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_DOUBLE_SAMPLE_EN_BIT  = 3;
	localparam int CTRL_CONTINUOUS_SAMPLE_EN_BIT  = 4;
	localparam int CTRL_SHIFT_LSB = 5;
	localparam int CTRL_GO_BIT    = 8;
	localparam int CTRL_CLR_BIT   = 9;

	localparam int STAT_DONE_BIT = 0;
	localparam int STAT_THR_BIT  = 1;
	localparam int STAT_OVF_BIT  = 2;

	localparam logic [CNT_W-1:0] CNT_SAT      = 8'hff;
	localparam logic [CNT_W-1:0] REPEAT_RST   = 8'h01;
	localparam int               CLEAR_CYCLES = 5;
endpackage

// file: verilog/adc_result_accumulator_filter.sv
// conversion result accumulator, averager and low-pass filter with apb registers
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
module adc_result_accumulator_filter #(
	parameter int CLEAR_LEN = adc_accum_pkg::CLEAR_CYCLES
) (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire adc_accum_pkg::apb_req_s      apbReq,
	output adc_accum_pkg::apb_rsp_s           apbRsp,
	input  wire adc_accum_pkg::conv_sample_s  sampleIn,
	input  wire logic                         extTriggerPin,
	output logic                              convStart,
	output logic                              irq,
	output logic [adc_accum_pkg::ACC_W-1:0]   filtered_out,
	output logic                              accum_overflow
);
	import adc_accum_pkg::*;

	compute_mode_e          compute_mode_sel_ff;
	logic                   double_sample_en_ff;
	logic                   continuous_sample_en_ff;
	logic [2:0]             shift_select_field_ff;
	logic                   convert_go_bit_ff;
	logic                   accum_clear_bit_ff;
	logic [CNT_W-1:0]       repeatTarget_ff;
	logic [ACC_W-1:0]       accum_value_ff;
	logic [CNT_W-1:0]       sample_count_ff;
	logic [ACC_W-1:0]       filtered_result_ff;
	logic                   accum_overflow_flag_ff;
	logic [ACC_W-1:0]       firstSample_ff;
	logic                   secondHalf_ff;
	logic                   burstFresh_ff;
	logic [STAT_W-1:0]      status_ff;
	logic [STAT_W-1:0]      mask_ff;
	logic [CLR_CNT_W-1:0]   clearCnt_ff;
	seq_state_e             state_ff;
	logic                   convStart_ff;
	logic                   irq_ff;
	apb_rsp_s               apbRsp_ff;
	logic [2:0]             extSync_ff;

	logic                   apbAccess;
	logic                   apbDone;
	logic                   wrEn;
	logic                   addrHit;
	logic [DATA_W-1:0]      rdData;
	logic                   extRise;
	logic                   swGo;
	logic                   trigEvent;
	logic                   procStep;
	logic                   firstHalf;
	logic                   fullStep;
	logic                   accumulating;
	logic                   restart;
	logic [ACC_W-1:0]       sampleVal;
	logic [ACC_W-1:0]       baseAcc;
	logic [CNT_W-1:0]       baseCnt;
	logic [CNT_W-1:0]       cntInc;
	logic [ACC_W:0]         sumWide;
	logic [ACC_W-1:0]       nxt_acc;
	logic                   testDue;
	logic                   testNow;
	logic                   keepGo;
	logic                   clearFinish;
	logic [STAT_W-1:0]      events;
	logic [STAT_W-1:0]      w1cMask;

	assign apbRsp         = apbRsp_ff;
	assign convStart      = convStart_ff;
	assign irq            = irq_ff;
	assign filtered_out   = filtered_result_ff;
	assign accum_overflow = accum_overflow_flag_ff;

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, so every reply leaves a flop

	assign apbAccess = apbReq.psel & apbReq.penable;
	assign apbDone   = apbAccess & apbRsp_ff.pready;
	assign wrEn      = apbDone & apbReq.pwrite;

	// address decode and read mux
	always_comb begin
		rdData  = '0;
		addrHit = 1'b1;
		if (apbReq.paddr == OFS_CTRL) begin
			rdData[CTRL_MODE_LSB +: 3]  = compute_mode_sel_ff;
			rdData[CTRL_DOUBLE_SAMPLE_EN_BIT]       = double_sample_en_ff;
			rdData[CTRL_CONTINUOUS_SAMPLE_EN_BIT]       = continuous_sample_en_ff;
			rdData[CTRL_SHIFT_LSB +: 3] = shift_select_field_ff;
			rdData[CTRL_GO_BIT]         = convert_go_bit_ff;
			rdData[CTRL_CLR_BIT]        = accum_clear_bit_ff;
		end else if (apbReq.paddr == OFS_REPEAT) begin
			rdData[CNT_W-1:0] = repeatTarget_ff;
		end else if (apbReq.paddr == OFS_ACCUM) begin
			rdData[ACC_W-1:0] = accum_value_ff;
		end else if (apbReq.paddr == OFS_COUNT) begin
			rdData[CNT_W-1:0] = sample_count_ff;
		end else if (apbReq.paddr == OFS_FILTER) begin
			rdData[ACC_W-1:0] = filtered_result_ff;
		end else if (apbReq.paddr == OFS_STATUS) begin
			rdData[STAT_W-1:0] = status_ff;
		end else if (apbReq.paddr == OFS_MASK) begin
			rdData[STAT_W-1:0] = mask_ff;
		end else if (apbReq.paddr == OFS_PREV) begin
			rdData[ACC_W-1:0] = firstSample_ff;
		end else begin
			addrHit = 1'b0;
		end
	end

	// reply is captured in the first access cycle and shown in the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			apbRsp_ff <= '0;
		end else if (apbAccess && !apbRsp_ff.pready) begin
			apbRsp_ff.pready  <= 1'b1;
			apbRsp_ff.prdata  <= apbReq.pwrite ? '0 : rdData;
			apbRsp_ff.pslverr <= ~addrHit;
		end else begin
			apbRsp_ff <= '0;
		end
	end

	// plain control fields
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			compute_mode_sel_ff     <= MODE_BASIC;
			double_sample_en_ff     <= 1'b0;
			continuous_sample_en_ff <= 1'b0;
			shift_select_field_ff   <= '0;
			repeatTarget_ff         <= REPEAT_RST;
			mask_ff                 <= '0;
		end else if (wrEn && apbReq.paddr == OFS_CTRL) begin
			compute_mode_sel_ff     <= compute_mode_e'(apbReq.pwdata[CTRL_MODE_LSB +: 3]);
			double_sample_en_ff     <= apbReq.pwdata[CTRL_DOUBLE_SAMPLE_EN_BIT];
			continuous_sample_en_ff <= apbReq.pwdata[CTRL_CONTINUOUS_SAMPLE_EN_BIT];
			shift_select_field_ff   <= apbReq.pwdata[CTRL_SHIFT_LSB +: 3];
		end else if (wrEn && apbReq.paddr == OFS_REPEAT) begin
			repeatTarget_ff <= apbReq.pwdata[CNT_W-1:0];
		end else if (wrEn && apbReq.paddr == OFS_MASK) begin
			mask_ff <= apbReq.pwdata[STAT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger sources

	// pin passes two flops; bit 2 only remembers the last synced level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			extSync_ff <= '0;
		end else begin
			extSync_ff <= {extSync_ff[1:0], extTriggerPin};
		end
	end

	assign extRise   = extSync_ff[1] & ~extSync_ff[2];
	assign swGo      = wrEn && apbReq.paddr == OFS_CTRL && apbReq.pwdata[CTRL_GO_BIT];
	// a trigger while go is already set is ignored
	assign trigEvent = (swGo | extRise) & ~convert_go_bit_ff;

	////////////////////////////////////////////////////////////////////////
	// sample arithmetic

	assign procStep     = (state_ff == ST_CONVERT) & sampleIn.valid;
	assign firstHalf    = double_sample_en_ff & ~secondHalf_ff;
	assign fullStep     = procStep & ~firstHalf;
	// reserved mode codes behave like basic mode
	assign accumulating = compute_mode_sel_ff inside {MODE_ACCUM, MODE_AVERAGE,
		MODE_BURST, MODE_LOWPASS};
	// wraps on purpose: the difference is a signed value in two's complement
	assign sampleVal    = double_sample_en_ff ?
		sampleIn.conversion_result - firstSample_ff : sampleIn.conversion_result;

	// average restarts once the target was met; burst at its opening trigger
	assign restart = (compute_mode_sel_ff == MODE_AVERAGE && sample_count_ff >= repeatTarget_ff) ||
		(compute_mode_sel_ff == MODE_BURST && burstFresh_ff);
	assign baseAcc = restart ? '0 : accum_value_ff;
	assign baseCnt = restart ? '0 : sample_count_ff;
	assign cntInc  = (baseCnt == CNT_SAT) ? baseCnt : baseCnt + 8'h01;

	// seventeen bits so the carry shows overflow
	always_comb begin
		sumWide = {1'b0, baseAcc};
		case (compute_mode_sel_ff)
			MODE_ACCUM,
			MODE_AVERAGE,
			MODE_BURST: begin
				sumWide = {1'b0, baseAcc} + {1'b0, sampleVal};
			end
			MODE_LOWPASS: begin
				// acc minus acc>>k never goes negative, so no borrow
				sumWide = {1'b0, baseAcc} - {1'b0, baseAcc >> shift_select_field_ff}
					+ {1'b0, sampleVal};
			end
			default: begin
				sumWide = {1'b0, baseAcc};
			end
		endcase
	end
	assign nxt_acc = sumWide[ACC_W-1:0];

	// when the threshold test runs
	always_comb begin
		case (compute_mode_sel_ff)
			MODE_AVERAGE,
			MODE_BURST,
			MODE_LOWPASS: testDue = cntInc >= repeatTarget_ff;
			default:      testDue = 1'b1;
		endcase
	end
	assign testNow = fullStep & testDue;

	// burst keeps retriggering below the target even without continuous mode
	assign keepGo = continuous_sample_en_ff |
		(compute_mode_sel_ff == MODE_BURST && cntInc < repeatTarget_ff);

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer

	// go bit: set by a trigger, kept by retriggering, otherwise dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			convert_go_bit_ff <= 1'b0;
		end else if (trigEvent) begin
			convert_go_bit_ff <= 1'b1;
		end else if (procStep) begin
			convert_go_bit_ff <= firstHalf ? continuous_sample_en_ff : keepGo;
		end
	end

	// a start waits until any clear is finished
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff     <= ST_IDLE;
			convStart_ff <= 1'b0;
		end else begin
			convStart_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (convert_go_bit_ff && !accum_clear_bit_ff) begin
						state_ff     <= ST_CONVERT;
						convStart_ff <= 1'b1;
					end
				end
				ST_CONVERT: begin
					if (sampleIn.valid) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// first of a pair is held; the second one finishes the pair
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			firstSample_ff <= '0;
			secondHalf_ff  <= 1'b0;
		end else if (procStep && firstHalf) begin
			firstSample_ff <= sampleIn.conversion_result;
			secondHalf_ff  <= 1'b1;
		end else if (fullStep) begin
			secondHalf_ff <= 1'b0;
		end
	end

	// remembers that the next full sample opens a new burst
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			burstFresh_ff <= 1'b0;
		end else if (trigEvent) begin
			burstFresh_ff <= 1'b1;
		end else if (fullStep) begin
			burstFresh_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator clear command

	assign clearFinish = accum_clear_bit_ff && clearCnt_ff == CLR_CNT_W'(CLEAR_LEN - 1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			accum_clear_bit_ff <= 1'b0;
			clearCnt_ff        <= '0;
		end else if (clearFinish) begin
			accum_clear_bit_ff <= 1'b0;
		end else if (accum_clear_bit_ff) begin
			clearCnt_ff <= clearCnt_ff + 3'h1;
		end else if (wrEn && apbReq.paddr == OFS_CTRL && apbReq.pwdata[CTRL_CLR_BIT]) begin
			accum_clear_bit_ff <= 1'b1;
			clearCnt_ff        <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator, count and filtered result

	// samples landing during a clear are dropped so the clear stays clean
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			accum_value_ff     <= '0;
			sample_count_ff    <= '0;
			filtered_result_ff <= '0;
		end else if (clearFinish) begin
			accum_value_ff  <= '0;
			sample_count_ff <= '0;
		end else if (fullStep && accumulating && !accum_clear_bit_ff) begin
			accum_value_ff     <= nxt_acc;
			sample_count_ff    <= cntInc;
			// right-justified whatever the output format
			filtered_result_ff <= nxt_acc >> shift_select_field_ff;
		end
	end

	// overflow flag: set by carry out, cleared only by the clear command
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			accum_overflow_flag_ff <= 1'b0;
		end else if (clearFinish) begin
			accum_overflow_flag_ff <= 1'b0;
		end else if (fullStep && accumulating && sumWide[ACC_W] && !accum_clear_bit_ff) begin
			accum_overflow_flag_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flags and interrupt

	assign events[STAT_DONE_BIT] = fullStep;
	assign events[STAT_THR_BIT]  = testNow & sampleIn.thresholdHit;
	assign events[STAT_OVF_BIT]  = fullStep & accumulating & sumWide[ACC_W] & ~accum_clear_bit_ff;
	assign w1cMask = (wrEn && apbReq.paddr == OFS_STATUS) ? apbReq.pwdata[STAT_W-1:0] : '0;

	// a new event beats a write-one-to-clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_ff <= '0;
		end else begin
			status_ff <= (status_ff & ~w1cMask) | events;
		end
	end

	// irq trails the status bits by one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_basic_hold: assert property (fullStep && compute_mode_sel_ff == MODE_BASIC && !clearFinish
		|=> $stable(accum_value_ff) && $stable(sample_count_ff))
		else $error("basic mode changed accumulator");

	a_accum_add: assert property (fullStep && compute_mode_sel_ff == MODE_ACCUM
		&& !accum_clear_bit_ff |=> accum_value_ff == $past(accum_value_ff) + $past(sampleVal))
		else $error("accumulate sum wrong");

	a_count_hold: assert property (fullStep && accumulating && !restart && !accum_clear_bit_ff
		&& sample_count_ff == CNT_SAT |=> sample_count_ff == CNT_SAT)
		else $error("count left saturation");

	a_shift_result: assert property (fullStep && accumulating && !accum_clear_bit_ff
		|=> filtered_result_ff == (accum_value_ff >> $past(shift_select_field_ff)))
		else $error("filtered result not shifted sum");

	a_clear_five: assert property ($rose(accum_clear_bit_ff)
		|-> accum_clear_bit_ff [*5] ##1 !accum_clear_bit_ff)
		else $error("clear did not take five cycles");

	a_clear_zero: assert property (clearFinish
		|=> accum_value_ff == '0 && sample_count_ff == '0 && !accum_overflow_flag_ff)
		else $error("clear left state behind");

	a_pair_done: assert property (procStep && firstHalf
		|=> !status_ff[STAT_DONE_BIT] || $past(status_ff[STAT_DONE_BIT]))
		else $error("done flagged on first of pair");

	a_burst_retrig: assert property (fullStep && compute_mode_sel_ff == MODE_BURST
		&& cntInc < repeatTarget_ff && !accum_clear_bit_ff |=> convert_go_bit_ff ##1 convStart_ff)
		else $error("burst did not retrigger");

	a_thr_flag: assert property (testNow && sampleIn.thresholdHit
		|=> status_ff[STAT_THR_BIT] ##1 irq_ff || !mask_ff[STAT_THR_BIT])
		else $error("threshold flag or irq missing");

	a_ovf_flag: assert property (fullStep && accumulating && sumWide[ACC_W]
		&& !accum_clear_bit_ff |=> accum_overflow_flag_ff)
		else $error("overflow not flagged");

	c_burst_end: cover property (fullStep && compute_mode_sel_ff == MODE_BURST && testNow);
	c_lowpass: cover property (fullStep && compute_mode_sel_ff == MODE_LOWPASS && testNow);
	c_pair: cover property (procStep && firstHalf ##[1:50] fullStep);
	c_clear: cover property (clearFinish);
endmodule

// file: verification/adc_core_model.sv
// behavioural converter core: one result per conversion start, after a chosen latency
`timescale 1ns/1ns
module adc_core_model (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic                   convStart,
	input  wire logic [7:0]             latency,
	input  wire logic [15:0]            nextResult,
	input  wire logic                   nextHit,
	output adc_accum_pkg::conv_sample_s sampleOut
);
	import adc_accum_pkg::*;
	logic       busy_ff;
	logic [7:0] waitCnt_ff;

	// data lines toggle outside the valid cycle so a stale result never passes for a new one
	always_ff @(posedge clk) begin
		sampleOut.valid             <= 1'b0;
		sampleOut.conversion_result <= ~sampleOut.conversion_result;
		sampleOut.thresholdHit      <= ~sampleOut.thresholdHit;
		if (busy_ff)
			waitCnt_ff <= waitCnt_ff - 8'h01;
		if (sys_rst) begin
			busy_ff    <= 1'b0;
			waitCnt_ff <= 8'h00;
			sampleOut  <= '0;
		end else if (busy_ff && waitCnt_ff == 8'h00) begin
			busy_ff   <= 1'b0;
			sampleOut <= '{1'b1, nextResult, nextHit};
		end else if (convStart && !busy_ff) begin
			busy_ff    <= 1'b1;
			waitCnt_ff <= latency;
		end
	end
endmodule

// file: verification/test_adc_result_accumulator_filter.sv
// self-checking bench for the conversion result accumulator and filter
`timescale 1ns/1ns
module test_adc_result_accumulator_filter;
	import adc_accum_pkg::*;
	logic             clk;
	logic             sys_rst;
	apb_req_s         apbReq;
	apb_rsp_s         apbRsp;
	conv_sample_s     sampleIn;
	logic             extTriggerPin;
	logic             convStart;
	logic             irq;
	logic [ACC_W-1:0] filtered_out;
	logic             accum_overflow;
	logic [7:0]       latency;
	logic [15:0]      nextResult;
	logic             nextHit;
	logic [16:0]      sampleQ[$];
	int               bad_count;
	int               check_count;
	logic [15:0]      accE, filtE, bs;
	logic [7:0]       cntE, rptE;
	logic [2:0]       modeE, shE, statE, maskE, stAcc;
	logic             ovfE, dsE, burstFirst, bh, err;
	logic [31:0]      rd;
	logic [2:0]       modes[5] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b111};

	adc_result_accumulator_filter #(.CLEAR_LEN(CLEAR_CYCLES)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.apbReq(apbReq), .apbRsp(apbRsp), .sampleIn(sampleIn), .extTriggerPin(extTriggerPin),
		.convStart(convStart), .irq(irq), .filtered_out(filtered_out), .accum_overflow(accum_overflow));
	adc_core_model i_core (.clk(clk), .sys_rst(sys_rst), .convStart(convStart), .latency(latency),
		.nextResult(nextResult), .nextHit(nextHit), .sampleOut(sampleIn));

	always #2 clk = ~clk;

	// every delivered result is queued; the next one is drawn at random so latency varies
	always @(posedge clk) begin
		if (sampleIn.valid === 1'b1) begin
			sampleQ.push_back({sampleIn.thresholdHit, sampleIn.conversion_result});
			nextResult <= 16'($urandom);
			nextHit    <= 1'($urandom);
			latency    <= 8'($urandom_range(12));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held until pready is seen high; release then one idle edge before the next
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		apbReq <= '{1'b1, 1'b0, wr, addr, data};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 50);
		rd = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge clk);
		if (n >= 50) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask

	function automatic logic [31:0] cfg();
		return {24'h0, shE, 1'b0, dsE, modeE};
	endfunction

	task automatic pop(output logic [15:0] s, output logic h);
		int n;
		n = 0;
		while (sampleQ.size() == 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (sampleQ.size() == 0) begin
			bad_count++;
			print_verdict();
		end else
			{h, s} = sampleQ.pop_front();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// expected effect of one full sample on accumulator, count, filter and status
	task automatic expect_step(input logic [15:0] s, input logic hit);
		logic [16:0] sum;
		logic        tst;
		tst = 1'b1;
		if ((modeE == MODE_AVERAGE && cntE >= rptE) || (modeE == MODE_BURST && burstFirst)) begin
			accE = 16'h0;
			cntE = 8'h0;
			burstFirst = 1'b0;
		end
		sum = 17'h0;
		if (modeE == MODE_LOWPASS)
			sum = {1'b0, accE - (accE >> shE)} + s;
		else if (modeE inside {MODE_ACCUM, MODE_AVERAGE, MODE_BURST})
			sum = {1'b0, accE} + s;
		if (modeE inside {MODE_ACCUM, MODE_AVERAGE, MODE_BURST, MODE_LOWPASS}) begin
			cntE = (cntE == CNT_SAT) ? cntE : cntE + 8'h01;
			accE = sum[15:0];
			ovfE |= sum[16];
			filtE = accE >> shE;
			tst = (modeE == MODE_ACCUM) || (cntE >= rptE);
		end
		statE = {sum[16], hit & tst, 1'b1};
	endtask

	task automatic check_all();
		repeat (3) @(posedge clk);
		rdchk("ACCUM", OFS_ACCUM, {16'h0, accE});
		rdchk("COUNT", OFS_COUNT, {24'h0, cntE});
		rdchk("FILTER", OFS_FILTER, {16'h0, filtE});
		rdchk("STATUS", OFS_STATUS, {29'h0, statE});
		check("filtered_out", {16'h0, filtE}, {16'h0, filtered_out});
		check("accum_overflow", {31'h0, ovfE}, {31'h0, accum_overflow});
		check("irq", {31'h0, |(statE & maskE)}, {31'h0, irq});
		wr(OFS_STATUS, 32'h7);
		repeat (3) @(posedge clk);
		check("irq cleared", 32'h0, {31'h0, irq});
	endtask

	// go bit or external pin, picked at random
	task automatic trigger();
		if ($urandom_range(1) == 0)
			wr(OFS_CTRL, cfg() | 32'h100);
		else begin
			extTriggerPin <= 1'b1;
			repeat (4) @(posedge clk);
			extTriggerPin <= 1'b0;
		end
	endtask

	task automatic step();
		logic [15:0] s1, s2;
		logic        h;
		maskE = 3'($urandom);
		wr(OFS_MASK, {29'h0, maskE});
		wr(OFS_STATUS, 32'h7);
		trigger();
		pop(s1, h);
		if (dsE) begin
			repeat (3) @(posedge clk);
			rdchk("PREV", OFS_PREV, {16'h0, s1});
			rdchk("STATUS first", OFS_STATUS, 32'h0);
			trigger();
			pop(s2, h);
			s1 = s2 - s1;
		end
		expect_step(s1, h);
		check_all();
	endtask

	// clear command stands for a fixed span, then accumulator, count and flag read zero
	task automatic clear_acc();
		wr(OFS_CTRL, cfg() | 32'h200);
		rdchk("clear busy", OFS_CTRL, cfg() | 32'h200);
		repeat (CLEAR_CYCLES) @(posedge clk);
		rdchk("clear done", OFS_CTRL, cfg());
		rdchk("ACCUM clr", OFS_ACCUM, 32'h0);
		rdchk("COUNT clr", OFS_COUNT, 32'h0);
		check("ovf clr", 32'h0, {31'h0, accum_overflow});
		accE = 16'h0;
		cntE = 8'h0;
		ovfE = 1'b0;
	endtask

	// continuous sampling runs on from one trigger until it is switched off; every result is then replayed
	task automatic continuous_run();
		modeE = MODE_ACCUM;
		dsE = 1'b0;
		clear_acc();
		maskE = 3'h7;
		wr(OFS_MASK, 32'h7);
		wr(OFS_STATUS, 32'h7);
		stAcc = 3'h0;
		wr(OFS_CTRL, cfg() | 32'h110);
		repeat (60) @(posedge clk);
		wr(OFS_CTRL, cfg());
		repeat (40) @(posedge clk);
		check("continuous_sample_en runs", 32'h1, {31'h0, sampleQ.size() > 2});
		while (sampleQ.size() > 0) begin
			pop(bs, bh);
			expect_step(bs, bh);
			stAcc |= statE;
		end
		statE = stAcc;
		check_all();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0; sys_rst = 1'b1; apbReq = '0; extTriggerPin = 1'b0;
		latency = 8'h0; nextResult = 16'h0; nextHit = 1'b0;
		bad_count = 0; check_count = 0; burstFirst = 1'b0;
		accE = 16'h0; filtE = 16'h0; cntE = 8'h0; ovfE = 1'b0;
		modeE = 3'h0; shE = 3'h0; dsE = 1'b0; rptE = REPEAT_RST;
		void'($urandom(32'h242f));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		// reset values, a read-only write and an unmapped address
		rdchk("CTRL rst", OFS_CTRL, 32'h0);
		rdchk("REPEAT rst", OFS_REPEAT, {24'h0, REPEAT_RST});
		rdchk("MASK rst", OFS_MASK, 32'h0);
		rdchk("FILTER rst", OFS_FILTER, 32'h0);
		wr(OFS_ACCUM, 32'hffff);
		rdchk("ACCUM ro", OFS_ACCUM, 32'h0);
		rdchk("COUNT rst", OFS_COUNT, 32'h0);
		wr(8'h20, 32'h5);
		check("slverr wr", 32'h1, {31'h0, err});
		rdchk("unmapped", 8'h20, 32'h0);
		check("slverr rd", 32'h1, {31'h0, err});
		// long accumulate run reaches count saturation; the other modes run short
		foreach (modes[i]) begin
			modeE = modes[i];
			shE = (modeE == MODE_LOWPASS) ? 3'($urandom_range(7, 1)) : 3'($urandom);
			dsE = (i > 0) ? 1'($urandom) : 1'b0;
			rptE = 8'($urandom_range(4, 1));
			wr(OFS_REPEAT, {24'h0, rptE});
			rdchk("REPEAT", OFS_REPEAT, {24'h0, rptE});
			clear_acc();
			repeat (i == 0 ? 258 : 12) step();
		end
		continuous_run();
		// burst: one trigger, retriggered until the target; the second burst restarts the sum
		modeE = MODE_BURST;
		dsE = 1'b0;
		clear_acc();
		repeat (2) begin
			shE = 3'($urandom);
			rptE = 8'($urandom_range(6, 2));
			wr(OFS_REPEAT, {24'h0, rptE});
			maskE = 3'h7;
			wr(OFS_MASK, 32'h7);
			wr(OFS_STATUS, 32'h7);
			burstFirst = 1'b1;
			stAcc = 3'h0;
			wr(OFS_CTRL, cfg() | 32'h100);
			repeat (rptE) begin
				pop(bs, bh);
				expect_step(bs, bh);
				stAcc |= statE;
			end
			repeat (40) @(posedge clk);
			check("burst stop", 32'h0, sampleQ.size());
			statE = stAcc;
			check_all();
		end
		print_verdict();
	end
endmodule
